/* File: core/rtcu_control.v */
// RTC control registers, write/read buffer transfers and done flags
// Summary of operation
// - Permit and format writes land in buffers; transfers move them only on request.
// - Permit bit 0 gates writes to the number-format bit; resets to 1.
// - Permit bit 1 gates writes to the hour-format bit; resets to 1.
// - Format bit 0 picks binary (0) or BCD (1); resets to 0.
// - Format bit 1 picks 12-hour (0) or 24-hour (1) mode.
// - Writing 1 to transfer bit 0 starts buffer-to-counter copy, 15ms.
// - Device clears the write request once the copy is done.
// - Clear-on-read bit selects read clear or host write-0 clear of flags.
// - Freeze bit halts seconds and all higher counters.
// - Writing 1 to transfer bit 4 starts counter-to-buffer copy, 15ms.
// - Device clears the read request once the copy is done.
// - Done flags raise on copy completion; host waits for them.
`timescale 1ns/1ns
`include "rtcu_defs.vh"
module rtcu_control
#(
  parameter CLK_MHZ = 50,
  parameter XFER_CYCLES = `RTCU_XFER_US * CLK_MHZ
)
(
  // Clock and backup-supply undervoltage reset
  input wire clk,
  input wire reset,
  // Register port from the link decoder
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata,
  // RTC timebase from the crystal domain
  input wire rtcTick,
  // Counter-side control state
  output reg numberFormatBcd,
  output reg hourFormat24,
  output wire secondsFreeze,
  output reg loadCounters,
  output reg captureCounters,
  output reg writeDoneFlag,
  output reg readDoneFlag
);
  localparam ST_IDLE = 2'b00;
  localparam ST_WRITE = 2'b01;
  localparam ST_READ = 2'b10;
  // Reset words, sliced per field below
  localparam [7:0] PERMIT_RST = `RTCU_RST_PERMIT;
  localparam [7:0] FORMAT_RST = `RTCU_RST_FORMAT;
  localparam [7:0] XFER_RST = `RTCU_RST_XFER;
  // Last countdown value; the count spans XFER_CYCLES clocks
  localparam [31:0] XFER_LAST = XFER_CYCLES - 1;

  // Write buffers and the read-back copies
  reg [1:0] permitBuf;
  reg [1:0] formatBuf;
  reg [1:0] permitRead;
  reg [1:0] formatRead;
  reg [1:0] permitLive;
  reg flagsClearOnRead;
  reg freeze;
  reg writeTransferRequest;
  reg readRefreshRequest;
  reg [1:0] state;
  reg [31:0] waitCount;
  reg [1:0] next_state;
  reg [31:0] next_waitCount;
  reg [7:0] next_regRdata;
  reg next_flagsClearOnRead;
  reg next_freeze;
  reg next_writeTransferRequest;
  reg next_readRefreshRequest;
  reg next_writeDoneFlag;
  reg next_readDoneFlag;
  wire tickRise;
  wire xferWrite;
  wire xferDoneWrite;
  wire xferDoneRead;
  wire flagWrite;
  wire doneRead;

  // Timebase arrives from another clock, so synchronise before use
  rtcu_sync tickSync
  (
    .clk(clk),
    .reset(reset),
    .asyncIn(rtcTick),
    .syncOut(),
    .rise(tickRise)
  );

  assign xferWrite = regWrite && (regAddr == `RTCU_ADDR_XFER);
  assign flagWrite = regWrite && (regAddr == `RTCU_ADDR_DONE);
  assign doneRead = regRead && (regAddr == `RTCU_ADDR_DONE);
  assign xferDoneWrite = (state == ST_WRITE) && (waitCount == 32'h0);
  assign xferDoneRead = (state == ST_READ) && (waitCount == 32'h0);
  assign secondsFreeze = freeze;

  // Buffer writes; live copies move only on a write transfer
  always @(posedge clk)
  begin
    if (reset)
    begin
      permitBuf <= PERMIT_RST[1:0];
      formatBuf <= FORMAT_RST[1:0];
      permitLive <= PERMIT_RST[1:0];
      numberFormatBcd <= FORMAT_RST[`RTCU_BIT_NUMFMT];
      hourFormat24 <= FORMAT_RST[`RTCU_BIT_HOURFMT];
    end
    else
    begin
      if (regWrite && regAddr == `RTCU_ADDR_PERMIT)
        permitBuf <= regWdata[1:0];
      if (regWrite && regAddr == `RTCU_ADDR_FORMAT)
      begin
        // Blocked bits keep their old buffered value
        if (permitBuf[`RTCU_BIT_NUMFMT])
          formatBuf[`RTCU_BIT_NUMFMT] <= regWdata[`RTCU_BIT_NUMFMT];
        if (permitBuf[`RTCU_BIT_HOURFMT])
          formatBuf[`RTCU_BIT_HOURFMT] <= regWdata[`RTCU_BIT_HOURFMT];
      end
      if (xferDoneWrite)
      begin
        // No hour conversion; the format bit just changes
        permitLive <= permitBuf;
        numberFormatBcd <= formatBuf[`RTCU_BIT_NUMFMT];
        hourFormat24 <= formatBuf[`RTCU_BIT_HOURFMT];
      end
    end
  end

  // Read-back copies follow the live state only on refresh
  always @(posedge clk)
  begin
    if (reset)
    begin
      permitRead <= PERMIT_RST[1:0];
      formatRead <= FORMAT_RST[1:0];
    end
    else if (xferDoneRead)
    begin
      permitRead <= permitLive;
      formatRead <= {hourFormat24, numberFormatBcd};
    end
  end

  // Transfer control register: set by host, requests cleared by hardware
  always @*
  begin
    next_flagsClearOnRead = flagsClearOnRead;
    next_freeze = freeze;
    next_writeTransferRequest = writeTransferRequest;
    next_readRefreshRequest = readRefreshRequest;
    if (xferWrite)
    begin
      next_flagsClearOnRead = regWdata[`RTCU_BIT_FCOR];
      next_freeze = regWdata[`RTCU_BIT_FREEZE];
    end
    // A request raised at the completion edge survives for another pass
    if (xferWrite && regWdata[`RTCU_BIT_WREQ])
      next_writeTransferRequest = 1'b1;
    else if (xferDoneWrite)
      next_writeTransferRequest = 1'b0;
    // Writing 0 never cancels a pending request
    if (xferWrite && regWdata[`RTCU_BIT_RREQ])
      next_readRefreshRequest = 1'b1;
    else if (xferDoneRead)
      next_readRefreshRequest = 1'b0;
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      flagsClearOnRead <= XFER_RST[`RTCU_BIT_FCOR];
      freeze <= XFER_RST[`RTCU_BIT_FREEZE];
      writeTransferRequest <= XFER_RST[`RTCU_BIT_WREQ];
      readRefreshRequest <= XFER_RST[`RTCU_BIT_RREQ];
    end
    else
    begin
      flagsClearOnRead <= next_flagsClearOnRead;
      freeze <= next_freeze;
      writeTransferRequest <= next_writeTransferRequest;
      readRefreshRequest <= next_readRefreshRequest;
    end
  end

  // One transfer at a time; write request wins when both pend
  always @*
  begin
    next_state = state;
    next_waitCount = waitCount;
    case (state)
      ST_IDLE:
      begin
        next_waitCount = XFER_LAST;
        // Start aligned to a timebase edge, as the counters live there
        if (tickRise && writeTransferRequest)
          next_state = ST_WRITE;
        else if (tickRise && readRefreshRequest)
          next_state = ST_READ;
      end
      ST_WRITE, ST_READ:
      begin
        if (waitCount == 32'h0)
          next_state = ST_IDLE;
        else
          next_waitCount = waitCount - 32'h1;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // Load and capture pulses rise together with the done flags
  always @(posedge clk)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      waitCount <= 32'h0;
      loadCounters <= 1'b0;
      captureCounters <= 1'b0;
    end
    else
    begin
      loadCounters <= xferDoneWrite;
      captureCounters <= xferDoneRead;
      state <= next_state;
      waitCount <= next_waitCount;
    end
  end

  // Done flags; completion wins over any clear in the same cycle
  always @*
  begin
    next_writeDoneFlag = writeDoneFlag;
    next_readDoneFlag = readDoneFlag;
    if (xferDoneWrite)
      next_writeDoneFlag = 1'b1;
    else if (doneRead && flagsClearOnRead)
      next_writeDoneFlag = 1'b0;
    else if (flagWrite && !flagsClearOnRead && !regWdata[`RTCU_BIT_WDONE])
      next_writeDoneFlag = 1'b0;
    if (xferDoneRead)
      next_readDoneFlag = 1'b1;
    else if (doneRead && flagsClearOnRead)
      next_readDoneFlag = 1'b0;
    else if (flagWrite && !flagsClearOnRead && !regWdata[`RTCU_BIT_RDONE])
      next_readDoneFlag = 1'b0;
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      writeDoneFlag <= 1'b0;
      readDoneFlag <= 1'b0;
    end
    else
    begin
      writeDoneFlag <= next_writeDoneFlag;
      readDoneFlag <= next_readDoneFlag;
    end
  end

  // Read mux; reserved bits read as zero, except transfer bit 3, which reads its reset value of 1
  always @*
  begin
    next_regRdata = 8'h00;
    case (regAddr)
      `RTCU_ADDR_PERMIT:
        next_regRdata[1:0] = permitRead;
      `RTCU_ADDR_FORMAT:
        next_regRdata[1:0] = formatRead;
      `RTCU_ADDR_XFER:
      begin
        next_regRdata[`RTCU_BIT_WREQ] = writeTransferRequest;
        next_regRdata[`RTCU_BIT_FCOR] = flagsClearOnRead;
        next_regRdata[`RTCU_BIT_FREEZE] = freeze;
        // Reserved bit keeps its reset value on read
        next_regRdata[`RTCU_BIT_RSV3] = XFER_RST[`RTCU_BIT_RSV3];
        next_regRdata[`RTCU_BIT_RREQ] = readRefreshRequest;
      end
      `RTCU_ADDR_DONE:
      begin
        next_regRdata[`RTCU_BIT_WDONE] = writeDoneFlag;
        next_regRdata[`RTCU_BIT_RDONE] = readDoneFlag;
      end
      default:
        next_regRdata = 8'h00;
    endcase
  end

  // Registered read data, valid the cycle after regRead, held until the next read
  always @(posedge clk)
  begin
    if (reset)
      regRdata <= 8'h00;
    else if (regRead)
      regRdata <= next_regRdata;
  end
endmodule // rtcu_control

/* File: core/rtcu_defs.vh */
// Constants for the RTC control and buffer-transfer block
`ifndef RTCU_DEFS_VH
`define RTCU_DEFS_VH
// Register addresses
`define RTCU_ADDR_PERMIT 8'h02
`define RTCU_ADDR_FORMAT 8'h03
`define RTCU_ADDR_XFER 8'h04
`define RTCU_ADDR_DONE 8'h05
// Reset values
`define RTCU_RST_PERMIT 8'h03
`define RTCU_RST_FORMAT 8'h00
`define RTCU_RST_XFER 8'h0a
// Bit positions
`define RTCU_BIT_NUMFMT 0
`define RTCU_BIT_HOURFMT 1
`define RTCU_BIT_WREQ 0
`define RTCU_BIT_FCOR 1
`define RTCU_BIT_FREEZE 2
`define RTCU_BIT_RSV3 3
`define RTCU_BIT_RREQ 4
`define RTCU_BIT_WDONE 0
`define RTCU_BIT_RDONE 1
// Transfer time in microseconds
`define RTCU_XFER_US 15000
`endif

/* File: core/rtcu_sync.v */
// Two-flop synchroniser with edge detect on the synchronised level
`timescale 1ns/1ns
module rtcu_sync
(
  // Clock and reset
  input wire clk,
  input wire reset,
  // Asynchronous level in, synchronised level and rising edge out
  input wire asyncIn,
  output reg syncOut,
  output wire rise
);
  reg stage1;
  reg prev;
  always @(posedge clk)
  begin
    if (reset)
    begin
      stage1 <= 1'b0;
      syncOut <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      stage1 <= asyncIn;
      syncOut <= stage1;
      prev <= syncOut;
    end
  end
  assign rise = syncOut & ~prev;
endmodule // rtcu_sync

/* File: verification/rtcu_control_properties.sv */
// Port assertions for the RTC control block
`timescale 1ns/1ns
module rtcu_control_properties
(
  // Clock and reset
  input wire clk,
  input wire reset,
  // Register port
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire [7:0] regRdata,
  // Timebase and counter side
  input wire rtcTick,
  input wire numberFormatBcd,
  input wire hourFormat24,
  input wire secondsFreeze,
  input wire loadCounters,
  input wire captureCounters,
  input wire writeDoneFlag,
  input wire readDoneFlag
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  load_after_done_a: assert property ($rose(writeDoneFlag) |-> loadCounters)
    else $error("load pulse missing");
  load_single_a: assert property (loadCounters |=> !loadCounters)
    else $error("load pulse too long");
  capture_after_done_a: assert property ($rose(readDoneFlag) |-> captureCounters)
    else $error("capture pulse missing");
  capture_single_a: assert property (captureCounters |=> !captureCounters)
    else $error("capture pulse too long");
  done_holds_a: assert property (writeDoneFlag && !regRead && !regWrite |=> writeDoneFlag)
    else $error("write done flag dropped");
  refresh_holds_a: assert property (readDoneFlag && !regRead && !regWrite |=> readDoneFlag)
    else $error("read done flag dropped");
  format_buffered_a: assert property (!loadCounters |->
    $stable({numberFormatBcd, hourFormat24}))
    else $error("format changed without transfer");
  one_transfer_a: assert property (!(loadCounters && captureCounters))
    else $error("load and capture together");
  unmapped_zero_a: assert property (regRead && (regAddr < 8'h02 || regAddr > 8'h05)
    |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  freeze_follows_a: assert property (regWrite && regAddr == 8'h04 |=>
    secondsFreeze == $past(regWdata[2]))
    else $error("freeze not following write");
  cover property ($rose(writeDoneFlag));
  cover property ($rose(readDoneFlag));
  cover property (secondsFreeze);
endmodule // rtcu_control_properties

/* File: verification/rtcu_timebase.sv */
// Free-running RTC timebase driven into the block
`timescale 1ns/1ns
module rtcu_timebase
(
  // Timebase out
  output reg rtcTick
);
  // Odd offset keeps its edges off the system clock edges
  initial
  begin
    rtcTick = 1'b0;
    #7;
    forever #80 rtcTick = ~rtcTick;
  end
endmodule // rtcu_timebase

/* File: verification/tb_top.sv */
// Self-checking bench for the RTC control block
`timescale 1ns/1ns
module tb_top;
  reg clk, reset, regWrite, regRead, rdPend = 1'b0;
  reg [7:0] regAddr, regWdata, p, d, fb;
  wire [7:0] regRdata;
  wire rtcTick, numberFormatBcd, hourFormat24, secondsFreeze;
  wire loadCounters, captureCounters, writeDoneFlag, readDoneFlag;
  integer failCount = 0, totalChecks = 0, seed = 32'h70123aab, i;
  logic [7:0] expQ[$];
  rtcu_timebase u_tbase (.rtcTick(rtcTick));
  // Short transfer count keeps the run brief
  rtcu_control #(.XFER_CYCLES(20)) u_dut (.clk(clk), .reset(reset), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .rtcTick(rtcTick), .numberFormatBcd(numberFormatBcd), .hourFormat24(hourFormat24),
    .secondsFreeze(secondsFreeze), .loadCounters(loadCounters),
    .captureCounters(captureCounters), .writeDoneFlag(writeDoneFlag),
    .readDoneFlag(readDoneFlag));
  task check(input [7:0] seen, input [7:0] want);
    begin
      totalChecks = totalChecks + 1;
      if (seen !== want)
      begin
        failCount = failCount + 1;
        $display("unexpected at %0t: seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task results;
    begin
      if (failCount == 0 && totalChecks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(negedge clk);
      regWrite = 1'b1;
      regAddr = a;
      regWdata = v;
      @(negedge clk);
      regWrite = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(negedge clk);
      regRead = 1'b1;
      regAddr = a;
      expQ.push_back(e);
      @(negedge clk);
      regRead = 1'b0;
    end
  endtask
  task wt(input integer b);
    integer n;
    begin
      n = 0;
      while (!(b ? readDoneFlag : writeDoneFlag) && n < 400)
      begin
        @(negedge clk);
        n = n + 1;
      end
      if (!(b ? readDoneFlag : writeDoneFlag))
      begin
        failCount = failCount + 1;
        results;
      end
    end
  endtask
  // Read data lands one cycle after the request
  always @(posedge clk)
    rdPend <= regRead;
  always @(negedge clk)
    if (rdPend)
      check(regRdata, expQ.pop_front());
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    reset = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    fb = 8'h00;
    // Count rising edges; the clock's first step from unknown is a falling one
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    rd(8'h02, 8'h03);
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h0a);
    rd(8'h05, 8'h00);
    rd(8'h41, 8'h00);
    for (i = 0; i < 4; i = i + 1)
    begin
      p = $random(seed) & 3;
      d = $random(seed) & 3;
      wr(8'h02, p);
      wr(8'h03, d);
      check({6'h0, hourFormat24, numberFormatBcd}, fb);
      fb = (fb & ~p) | (d & p);
      wr(8'h04, 8'h0b); // Transfer after each format change also reloads time
      wt(0);
      check({6'h0, hourFormat24, numberFormatBcd}, fb);
      rd(8'h05, 8'h01);
      rd(8'h05, 8'h00);
      rd(8'h04, 8'h0a);
    end
    wr(8'h04, 8'h10);
    wt(1);
    rd(8'h05, 8'h02);
    rd(8'h05, 8'h02);
    rd(8'h04, 8'h08);
    rd(8'h02, p);
    rd(8'h03, fb);
    wr(8'h05, 8'h00);
    rd(8'h05, 8'h00);
    wr(8'h04, 8'h0e);
    check({7'h0, secondsFreeze}, 8'h01);
    wr(8'h04, 8'h0a);
    check({7'h0, secondsFreeze}, 8'h00);
    repeat (2) @(negedge clk);
    results;
  end
endmodule // tb_top
bind rtcu_control rtcu_control_properties u_chk (.clk(clk), .reset(reset),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
  .regRdata(regRdata), .rtcTick(rtcTick), .numberFormatBcd(numberFormatBcd),
  .hourFormat24(hourFormat24), .secondsFreeze(secondsFreeze),
  .loadCounters(loadCounters), .captureCounters(captureCounters),
  .writeDoneFlag(writeDoneFlag), .readDoneFlag(readDoneFlag));
